/* File: rtl/servo_brake_pkg.sv */
// Purpose: Constants for servo status and brake sequencing
// Assumes: 20 MHz clk_sys, 1 ms time base
// Notes: AXI4-Lite register map and reset values
// Functional notes
// - Zero delay: completion decision starts immediately
// - Nonzero delay postpones decision by setting ms
// - Position command during delay resets timer
// - Delay measured from zero after command ends
// - Threshold compares speed magnitude, both directions
// - Ten r/min hysteresis around zero-speed threshold
// - Stalled servo-off: energized for stall delay
// - Running servo-off: release drops after running delay
// - Release drops at delay or low speed
// - Brake release speed 30 to 3000, default 30
package servo_brake_pkg;
	localparam int          CLK_HZ          = 20000000;
	localparam int          TICK_MS         = 1;
	localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] ZERO_HYST       = 16'h000a;
	localparam logic [15:0] RST_POS_DELAY   = 16'h0000;
	localparam logic [15:0] RST_ZERO_THR    = 16'h0032;
	localparam logic [15:0] RST_STALL_DELAY = 16'h0000;
	localparam logic [15:0] RST_RUN_DELAY   = 16'h0000;
	localparam logic [15:0] RST_REL_SPEED   = 16'h001e;
	localparam logic [15:0] REL_SPEED_MIN   = 16'h001e;
	localparam logic [15:0] REL_SPEED_MAX   = 16'h0bb8;
	localparam logic [15:0] POS_DELAY_MAX   = 16'h7530;
	localparam logic [15:0] BRK_DELAY_MAX   = 16'h7d00;
	localparam logic [7:0]  ADDR_POS_DELAY  = 8'h00;
	localparam logic [7:0]  ADDR_ZERO_THR   = 8'h04;
	localparam logic [7:0]  ADDR_STALL      = 8'h08;
	localparam logic [7:0]  ADDR_RUN        = 8'h0c;
	localparam logic [7:0]  ADDR_REL_SPEED  = 8'h10;
	localparam logic [7:0]  ADDR_STATUS     = 8'h14;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

/* File: rtl/ms_timer.sv */
// Purpose: Millisecond counter driven by shared tick
// Assumes: tick is one cycle per ms
// Notes: Clear has priority over counting; saturates
`timescale 1ns/1ps
module ms_timer (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        clear,
	input  wire logic        tick,
	output logic      [15:0] count
);
	// Count ms while not cleared, hold at top
	always_ff @(posedge clk_sys) begin
		if (!nrst || clear) begin
			count <= 16'h0000;
		end else if (tick && count != 16'hffff) begin
			count <= count + 16'h0001;
		end
	end
endmodule

/* File: rtl/servo_status_brake_sequencer.sv */
// Purpose: Position-done delay, zero-speed flag, brake sequencing
// Assumes: Speed is signed r/min, synchronous inputs
// Notes: Registers over AXI4-Lite, one word each
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module servo_status_brake_sequencer (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        servo_on_in,
	input  wire logic        position_cmd_active,
	input  wire logic signed [15:0] motor_speed,
	output logic             brake_release_out,
	output logic             motor_energize,
	output logic             zero_speed_flag,
	output logic             position_decision_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef enum logic [3:0] {
		ST_OFF     = 4'b0001,
		ST_ON      = 4'b0010,
		ST_STALL   = 4'b0100,
		ST_RUNOFF  = 4'b1000
	} brake_state_e;

	brake_state_e state;
	brake_state_e next_state;
	logic [15:0]  pos_delay;
	logic [15:0]  zero_thresh;
	logic [15:0]  stall_delay;
	logic [15:0]  run_delay;
	logic [15:0]  rel_speed;
	logic [15:0]  tick_cnt;
	logic         tick;
	logic [15:0]  pos_count;
	logic [15:0]  brk_count;
	logic         pos_armed;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_held;
	logic        w_held;

	// Single 1 ms tick divider
	always_ff @(posedge clk_sys) begin
		if (!nrst || tick) begin
			tick_cnt <= 16'h0000;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end
	assign tick = (tick_cnt == 16'(servo_brake_pkg::TICK_CYCLES - 1));

	// Speed magnitude and threshold compares
	wire [15:0] speed_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
	wire [16:0] zero_hi   = {1'b0, zero_thresh} + {1'b0, servo_brake_pkg::ZERO_HYST};
	wire        zero_low  = zero_thresh > servo_brake_pkg::ZERO_HYST ?
	                        (speed_abs < zero_thresh - servo_brake_pkg::ZERO_HYST) : (speed_abs == 16'h0000);
	wire        zero_high = {1'b0, speed_abs} > zero_hi;
	wire        below_rel = speed_abs < rel_speed;

	// Zero-speed flag with hysteresis band
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			zero_speed_flag <= 1'b0;
		end else if (zero_low) begin
			zero_speed_flag <= 1'b1;
		end else if (zero_high) begin
			zero_speed_flag <= 1'b0;
		end
	end

	// Position delay timer: cleared while command present
	ms_timer u_pos_timer (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.clear   (position_cmd_active),
		.tick    (tick),
		.count   (pos_count)
	);

	// Decision enable after falling command edge plus delay
	wire pos_expired = (pos_delay == 16'h0000) || (pos_count >= pos_delay);
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pos_armed            <= 1'b0;
			position_decision_en <= 1'b0;
		end else if (position_cmd_active) begin
			pos_armed            <= 1'b1;
			position_decision_en <= 1'b0;
		end else if (pos_armed && pos_expired) begin
			pos_armed            <= 1'b0;
			position_decision_en <= 1'b1;
		end
	end

	// Brake sequence timer, cleared on state entry
	wire brk_clear = (state != next_state) || (state == ST_ON) || (state == ST_OFF);
	ms_timer u_brk_timer (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.clear   (brk_clear),
		.tick    (tick),
		.count   (brk_count)
	);

	// Brake sequence next-state
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (servo_on_in) begin
					next_state = ST_ON;
				end
			end
			ST_ON: begin
				if (!servo_on_in) begin
					next_state = zero_speed_flag ? ST_STALL : ST_RUNOFF;
				end
			end
			ST_STALL: begin
				if (brk_count >= stall_delay) begin
					next_state = ST_OFF;
				end
			end
			ST_RUNOFF: begin
				if (brk_count >= run_delay || below_rel) begin
					next_state = ST_OFF;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	// State register and registered outputs
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state             <= ST_OFF;
			brake_release_out <= 1'b0;
			motor_energize    <= 1'b0;
		end else begin
			state             <= next_state;
			brake_release_out <= (next_state == ST_ON) || (next_state == ST_RUNOFF);
			motor_energize    <= (next_state == ST_ON) || (next_state == ST_STALL);
		end
	end

	// AXI write path: take address and data in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire wr_go   = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !aw_take;
			s_axi_wready  <= !w_held && !w_take;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write decode and merged data with byte strobes
	wire [15:0] wmerge_pos   = {w_strb[1] ? w_data[15:8] : pos_delay[15:8], w_strb[0] ? w_data[7:0] : pos_delay[7:0]};
	wire [15:0] wmerge_zero  = {w_strb[1] ? w_data[15:8] : zero_thresh[15:8], w_strb[0] ? w_data[7:0] : zero_thresh[7:0]};
	wire [15:0] wmerge_stall = {w_strb[1] ? w_data[15:8] : stall_delay[15:8], w_strb[0] ? w_data[7:0] : stall_delay[7:0]};
	wire [15:0] wmerge_run   = {w_strb[1] ? w_data[15:8] : run_delay[15:8], w_strb[0] ? w_data[7:0] : run_delay[7:0]};
	wire [15:0] wmerge_rel   = {w_strb[1] ? w_data[15:8] : rel_speed[15:8], w_strb[0] ? w_data[7:0] : rel_speed[7:0]};
	wire        wr_known     = aw_addr == servo_brake_pkg::ADDR_POS_DELAY || aw_addr == servo_brake_pkg::ADDR_ZERO_THR ||
	                           aw_addr == servo_brake_pkg::ADDR_STALL || aw_addr == servo_brake_pkg::ADDR_RUN ||
	                           aw_addr == servo_brake_pkg::ADDR_REL_SPEED || aw_addr == servo_brake_pkg::ADDR_STATUS;

	// Parameter registers, ranges clamped except zero threshold
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pos_delay   <= servo_brake_pkg::RST_POS_DELAY;
			zero_thresh <= servo_brake_pkg::RST_ZERO_THR;
			stall_delay <= servo_brake_pkg::RST_STALL_DELAY;
			run_delay   <= servo_brake_pkg::RST_RUN_DELAY;
			rel_speed   <= servo_brake_pkg::RST_REL_SPEED;
		end else if (wr_go) begin
			case (aw_addr)
				servo_brake_pkg::ADDR_POS_DELAY: begin
					pos_delay <= (wmerge_pos > servo_brake_pkg::POS_DELAY_MAX) ? servo_brake_pkg::POS_DELAY_MAX : wmerge_pos;
				end
				servo_brake_pkg::ADDR_ZERO_THR: begin
					zero_thresh <= wmerge_zero;
				end
				servo_brake_pkg::ADDR_STALL: begin
					stall_delay <= (wmerge_stall > servo_brake_pkg::BRK_DELAY_MAX) ? servo_brake_pkg::BRK_DELAY_MAX : wmerge_stall;
				end
				servo_brake_pkg::ADDR_RUN: begin
					run_delay <= (wmerge_run > servo_brake_pkg::BRK_DELAY_MAX) ? servo_brake_pkg::BRK_DELAY_MAX : wmerge_run;
				end
				servo_brake_pkg::ADDR_REL_SPEED: begin
					rel_speed <= (wmerge_rel < servo_brake_pkg::REL_SPEED_MIN) ? servo_brake_pkg::REL_SPEED_MIN :
					             (wmerge_rel > servo_brake_pkg::REL_SPEED_MAX) ? servo_brake_pkg::REL_SPEED_MAX : wmerge_rel;
				end
				default: begin
				end
			endcase
		end
	end

	// Write response
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= servo_brake_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_known ? servo_brake_pkg::RESP_OKAY : servo_brake_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode; status shows live block state
	wire [31:0] status_word = {24'h00_0000, state, position_decision_en, zero_speed_flag, motor_energize, brake_release_out};
	wire        rd_known    = s_axi_araddr <= servo_brake_pkg::ADDR_STATUS && s_axi_araddr[1:0] == 2'b00;
	wire [31:0] rd_word     = (s_axi_araddr == servo_brake_pkg::ADDR_POS_DELAY)  ? {16'h0000, pos_delay} :
	                          (s_axi_araddr == servo_brake_pkg::ADDR_ZERO_THR)   ? {16'h0000, zero_thresh} :
	                          (s_axi_araddr == servo_brake_pkg::ADDR_STALL)      ? {16'h0000, stall_delay} :
	                          (s_axi_araddr == servo_brake_pkg::ADDR_RUN)        ? {16'h0000, run_delay} :
	                          (s_axi_araddr == servo_brake_pkg::ADDR_REL_SPEED)  ? {16'h0000, rel_speed} :
	                          (s_axi_araddr == servo_brake_pkg::ADDR_STATUS)     ? status_word : 32'h0000_0000;

	// Read channel: one read at a time
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= servo_brake_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_known ? servo_brake_pkg::RESP_OKAY : servo_brake_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule

/* File: testbench/servo_status_brake_sequencer_chk.sv */
// Purpose: Port checker for the servo status and brake sequencer
// Assumes: Synchronous active-low reset on clk_sys
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module servo_status_brake_sequencer_chk (
	input wire logic               clk_sys,
	input wire logic               nrst,
	input wire logic               servo_on_in,
	input wire logic               position_cmd_active,
	input wire logic signed [15:0] motor_speed,
	input wire logic               brake_release_out,
	input wire logic               motor_energize,
	input wire logic               zero_speed_flag,
	input wire logic               position_decision_en,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Pin behaviour
	a_reset_clears: assert property ($rose(nrst) |-> !brake_release_out && !motor_energize && !zero_speed_flag)
		else $error("outputs not clear after reset");
	a_power_up: assert property ($rose(servo_on_in) && !brake_release_out && !motor_energize
		|-> ##[1:3] brake_release_out && motor_energize) else $error("servo-on not applied");
	a_stall_release: assert property ($fell(servo_on_in) && zero_speed_flag && brake_release_out
		|-> ##[1:2] !brake_release_out) else $error("stall release not dropped");
	a_run_energy: assert property ($fell(servo_on_in) && !zero_speed_flag && motor_energize
		|-> ##[1:2] !motor_energize) else $error("running energize not dropped");
	a_zero_rest: assert property ((motor_speed == 16'h0000) [*4] |-> zero_speed_flag)
		else $error("zero speed flag missing at rest");
	a_cmd_blocks: assert property (position_cmd_active |=> !position_decision_en)
		else $error("decision running during command");
	// Register bus handshakes
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
endmodule
bind servo_status_brake_sequencer servo_status_brake_sequencer_chk i_chk (.*);

/* File: testbench/brake_model.sv */
// Purpose: Holding brake that engages some time after release drops
// Assumes: Engagement time in clk_sys cycles
// Notes: Releasing takes effect at once
`timescale 1ns/1ps
module brake_model #(
	parameter int ENGAGE_CYCLES = 1000
) (
	input  wire logic clk_sys,
	input  wire logic brake_release_out,
	output logic      brake_engaged
);
	int hold_cnt = 0;
	// Mechanical lag after the release command drops
	always @(posedge clk_sys) begin
		if (brake_release_out)
			hold_cnt <= 0;
		else if (hold_cnt < ENGAGE_CYCLES)
			hold_cnt <= hold_cnt + 1;
	end
	assign brake_engaged = !brake_release_out && (hold_cnt >= ENGAGE_CYCLES);
endmodule

/* File: testbench/servo_status_brake_sequencer_tb.sv */
// Purpose: Self-checking bench for the servo status and brake sequencer
// Assumes: 20 MHz clock, real 1 ms tick
// Notes: Register rows first, then pin scenarios
`timescale 1ns/1ps
module servo_status_brake_sequencer_tb;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_s;
	localparam logic [1:0] OK = servo_brake_pkg::RESP_OKAY;
	localparam logic [1:0] SE = servo_brake_pkg::RESP_SLVERR;
	row_s rows [10] = '{'{1'b0, 8'h00, 32'h0, 32'h0, OK}, '{1'b0, 8'h04, 32'h0, 32'h0032, OK},
		'{1'b0, 8'h08, 32'h0, 32'h0, OK}, '{1'b0, 8'h0c, 32'h0, 32'h0, OK}, '{1'b0, 8'h10, 32'h0, 32'h001e, OK},
		'{1'b0, 8'h18, 32'h0, 32'h0, SE}, '{1'b1, 8'h10, 32'h0005, 32'h001e, OK},
		'{1'b1, 8'h10, 32'hffff, 32'h0bb8, OK}, '{1'b1, 8'h08, 32'h7d01, 32'h7d00, OK}, '{1'b1, 8'h20, 32'h1, 32'h0, SE}};
	logic [15:0] speeds [8] = '{16'h0064, 16'h006f, 16'h005f, 16'h0059, 16'hff97, 16'hff91, 16'hffa1, 16'hffa7};
	logic zero_exp [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic clk_sys = 1'b0, nrst = 1'b0, servo_on_in = 1'b0, position_cmd_active = 1'b0;
	logic signed [15:0] motor_speed = 16'h0000;
	logic brake_release_out, motor_energize, zero_speed_flag, position_decision_en, brake_engaged;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int err_count = 0, cmp_count = 0, cyc = 0, n, nd, ne;
	servo_status_brake_sequencer i_servo_status_brake_sequencer (.*);
	brake_model #(.ENGAGE_CYCLES(1000)) i_brake_model (.*);
	initial forever #25 clk_sys = ~clk_sys;
	// Run ceiling
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			err_count++;
			conclude();
		end
	end
	task conclude();
		if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Waits end on the falling edge, where outputs are settled
	task wt(input int k);
		repeat (k) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge clk_sys);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!tb) begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		tr = 1'b0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		while (!tr) begin
			@(negedge clk_sys);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			{d, r} = {s_axi_rdata, s_axi_rresp};
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	// Main sequence
	initial begin
		wt(5);
		chk("reset_outputs", 32'h0, {29'h0, brake_release_out, motor_energize, zero_speed_flag});
		@(posedge clk_sys);
		nrst <= 1'b1;
		wt(2);
		for (int i = 0; i < 10; i++) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].d, rs);
				chk("bresp", {30'h0, rows[i].r}, {30'h0, rs});
			end
			axi_rd(rows[i].a, rd, rs);
			chk("rdata", rows[i].e, rd);
			chk("rresp", {30'h0, rows[i].r}, {30'h0, rs});
		end
		axi_wr(8'h04, 32'h0064, rs);
		axi_wr(8'h10, 32'h00c8, rs);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			motor_speed <= speeds[i];
			wt(4);
			chk("zero_speed", {31'h0, zero_exp[i]}, {31'h0, zero_speed_flag});
		end
		@(posedge clk_sys);
		{motor_speed, position_cmd_active} <= {16'h0000, 1'b1};
		wt(3);
		chk("decision_cmd", 32'h0, {31'h0, position_decision_en});
		@(posedge clk_sys);
		position_cmd_active <= 1'b0;
		wt(3);
		chk("decision_zero", 32'h1, {31'h0, position_decision_en});
		axi_wr(8'h00, 32'h0002, rs);
		axi_wr(8'h08, 32'h0002, rs);
		@(posedge clk_sys);
		{servo_on_in, position_cmd_active} <= 2'b11;
		wt(4);
		chk("servo_on", 32'h3, {30'h0, brake_release_out, motor_energize});
		@(posedge clk_sys);
		position_cmd_active <= 1'b0;
		wt(100);
		@(posedge clk_sys);
		position_cmd_active <= 1'b1;
		wt(2);
		chk("decision_restart", 32'h0, {31'h0, position_decision_en});
		@(posedge clk_sys);
		{servo_on_in, position_cmd_active} <= 2'b00;
		wt(3);
		chk("stall_off", 32'h1, {30'h0, brake_release_out, motor_energize});
		{n, nd, ne} = {32'd0, 32'd0, 32'd0};
		while (position_decision_en !== 1'b1 || motor_energize !== 1'b0) begin
			wt(1);
			n++;
			if (position_decision_en !== 1'b1) nd = n;
			if (motor_energize !== 1'b0) ne = n;
		end
		chk("decision_wait", 32'h1, {31'h0, nd > 19000});
		chk("decision_bound", 32'h1, {31'h0, nd < 40100});
		chk("energize_wait", 32'h1, {31'h0, ne > 19000});
		chk("energize_bound", 32'h1, {31'h0, ne < 40100});
		chk("brake_engaged", 32'h1, {31'h0, brake_engaged});
		axi_wr(8'h0c, 32'h7d00, rs);
		@(posedge clk_sys);
		{motor_speed, servo_on_in} <= {16'h01f4, 1'b1};
		wt(4);
		@(posedge clk_sys);
		servo_on_in <= 1'b0;
		wt(3);
		chk("run_off", 32'h2, {30'h0, brake_release_out, motor_energize});
		axi_rd(8'h14, rd, rs);
		chk("status_runoff", 32'h0000_0089, rd);
		@(posedge clk_sys);
		motor_speed <= 16'h0096;
		wt(3);
		chk("run_slow", 32'h0, {31'h0, brake_release_out});
		axi_wr(8'h0c, 32'h0000, rs);
		@(posedge clk_sys);
		{motor_speed, servo_on_in} <= {16'h01f4, 1'b1};
		wt(4);
		@(posedge clk_sys);
		servo_on_in <= 1'b0;
		n = 0;
		while (brake_release_out !== 1'b0) begin
			wt(1);
			n++;
		end
		chk("run_zero_delay", 32'h1, {31'h0, n < 20010});
		// Mid-run reset while energized
		@(posedge clk_sys);
		servo_on_in <= 1'b1;
		wt(4);
		@(posedge clk_sys);
		nrst <= 1'b0;
		wt(2);
		chk("reset_midrun", 32'h0, {29'h0, brake_release_out, motor_energize, zero_speed_flag});
		@(posedge clk_sys);
		nrst <= 1'b1;
		wt(2);
		axi_rd(8'h08, rd, rs);
		chk("stall_after_reset", 32'h0, rd);
		conclude();
	end
endmodule
